// [buck_standby_mode_control.sv]
// operating mode, set point and power-good control for the buck regulators
//
// Overview of operation
// - standby input acts only in the on state
// - qualified level one means standby, zero not
// - low power off config overrides standby config
// - entry delay of zero to three slow ticks
// - entry delayed, exit from standby immediate
// - synchroniser adds two system clock cycles
// - mode field off/pwm/pfm/aps pairs, reserved codes
// - mode field dual active normal/standby pairs
// - readback returns written mode, not effective mode
// - start-up slot reloads mode from profile
// - standby set point resets to profile set point
// - voltage changes ramp with controlled slope
// - low power off active regulator uses standby point
// - memory hold bit selects off or pfm
// - user off bit selects off or pfm
// - low power off regulators hold until slot
// - power good low until new point reached
// - soft-start pfm, aps, pwm, settle, selected
// - regulators come up in pfm mode
// - standby pin xor polarity invert bit
`timescale 1ns/10ps
module buck_standby_mode_control #(
  parameter int unsigned NUM_BUCKS     = 6,
  parameter int unsigned SETTLE_CYCLES = buck_mode_pkg::SETTLE_CYCLES
) (
  input  wire logic                                                 clk_in,
  input  wire logic                                                 rst_in,
  input  wire logic                                                 standby_pin_in,
  input  wire logic                                                 standby_polarity_invert_in,
  input  wire logic [buck_mode_pkg::DLY_W-1:0]                      standby_entry_delay_in,
  input  wire buck_mode_pkg::pwr_state_t                            pwr_state_in,
  input  wire logic                                                 low_power_off_request_in,
  input  wire logic [NUM_BUCKS-1:0]                                 startup_slot_in,
  input  wire buck_mode_pkg::buck_cfg_t [NUM_BUCKS-1:0]             startup_profile_select_in,
  input  wire buck_mode_pkg::buck_write_t [NUM_BUCKS-1:0]           buck_write_in,
  input  wire logic [NUM_BUCKS-1:0]                                 buck_memhold_mode_in,
  input  wire logic [NUM_BUCKS-1:0]                                 buck_useroff_mode_in,
  output logic                                                      standby_active_out,
  output buck_mode_pkg::op_mode_t [NUM_BUCKS-1:0]                   buck_mode_out,
  output logic [NUM_BUCKS-1:0][buck_mode_pkg::SP_W-1:0]             buck_vout_code_out,
  output logic [NUM_BUCKS-1:0]                                      buck_power_good_out,
  output logic [NUM_BUCKS-1:0][buck_mode_pkg::MODE_W-1:0]           buck_mode_select_out,
  output logic [NUM_BUCKS-1:0][buck_mode_pkg::STBY_SP_W-1:0]        buck_standby_setpoint_out
);

  // refuse sizes the logic cannot serve
  if ((NUM_BUCKS < 1) || (NUM_BUCKS > 8))
  begin : g_bad_count
    $error("NUM_BUCKS must lie between 1 and 8");
  end
  if ((SETTLE_CYCLES < 1) || (SETTLE_CYCLES >= (1 << buck_mode_pkg::SETTLE_W)))
  begin : g_bad_settle
    $error("SETTLE_CYCLES does not fit the settle counter");
  end

  localparam logic [buck_mode_pkg::SETTLE_W-1:0] SETTLE_LOAD =
    buck_mode_pkg::SETTLE_W'(SETTLE_CYCLES - 1);
  localparam logic [buck_mode_pkg::TICK_W-1:0] TICK_LAST =
    buck_mode_pkg::TICK_W'(buck_mode_pkg::TICK_CYCLES - 1);

  // whole state of the block apart from the slope generators
  typedef struct packed {
    logic [buck_mode_pkg::TICK_W-1:0]           tick_cnt;
    logic                                       tick;
    logic                                       sync_1;
    logic                                       sync_2;
    logic [buck_mode_pkg::DLY_W-1:0]            dly_cnt;
    logic                                       stby;
    logic                                       init_done;
    buck_mode_pkg::buck_state_t [NUM_BUCKS-1:0] bucks;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  // ramp feedback from the slope generators
  logic [NUM_BUCKS-1:0]                         at_target;
  logic [NUM_BUCKS-1:0][buck_mode_pkg::SP_W-1:0] vout_code;
  logic [NUM_BUCKS-1:0]                         ramp_enable;

  // next state of timebase, standby qualifier and every regulator
  always_comb
  begin
    logic                                 lp_active;
    logic                                 lp_bit;
    logic                                 hold;
    buck_mode_pkg::op_mode_t              want_mode;
    logic [buck_mode_pkg::SP_W-1:0]       want_sp;
    buck_mode_pkg::buck_state_t           b;
    lp_active = 1'b0;
    lp_bit    = 1'b0;
    hold      = 1'b0;
    want_mode = buck_mode_pkg::MODE_OFF;
    want_sp   = '0;
    b         = '0;
    state_next = state_reg;

    // slow tick derived from the system clock
    if (state_reg.tick_cnt == TICK_LAST)
    begin
      state_next.tick_cnt = '0;
      state_next.tick     = 1'b1;
    end
    else
    begin
      state_next.tick_cnt = state_reg.tick_cnt + buck_mode_pkg::TICK_W'(1);
      state_next.tick     = 1'b0;
    end

    // polarity applied ahead of a two-stage synchroniser
    state_next.sync_1 = standby_pin_in ^ standby_polarity_invert_in;
    state_next.sync_2 = state_reg.sync_1;

    // standby qualification with delayed entry and immediate exit
    if (pwr_state_in != buck_mode_pkg::PWR_ON)
    begin
      state_next.stby    = 1'b0;
      state_next.dly_cnt = '0;
    end
    else if (!state_reg.sync_2)
    begin
      state_next.stby    = 1'b0;
      state_next.dly_cnt = '0;
    end
    else if (!state_reg.stby)
    begin
      if (standby_entry_delay_in == buck_mode_pkg::STBY_DLY_NONE)
      begin
        state_next.stby = 1'b1;
      end
      else if (state_reg.tick)
      begin
        if ((state_reg.dly_cnt + buck_mode_pkg::DLY_W'(1)) == standby_entry_delay_in)
        begin
          state_next.stby    = 1'b1;
          state_next.dly_cnt = '0;
        end
        else
        begin
          state_next.dly_cnt = state_reg.dly_cnt + buck_mode_pkg::DLY_W'(1);
        end
      end
    end

    // low power off configuration has priority over standby
    lp_active = (pwr_state_in == buck_mode_pkg::PWR_MEMHOLD) ||
                (pwr_state_in == buck_mode_pkg::PWR_USEROFF) ||
                low_power_off_request_in;

    state_next.init_done = 1'b1;

    for (int i = 0; i < NUM_BUCKS; i++)
    begin
      b = state_reg.bucks[i];

      // first cycle after reset takes the start-up profile
      if (!state_reg.init_done)
      begin
        b.mode          = startup_profile_select_in[i].mode;
        b.setpoint      = startup_profile_select_in[i].setpoint;
        b.stby_setpoint = startup_profile_select_in[i].setpoint[buck_mode_pkg::STBY_SP_W-1:0];
      end

      // software writes store the value as written
      if (buck_write_in[i].mode_we)
      begin
        b.mode = buck_write_in[i].mode;
      end
      if (buck_write_in[i].sp_we)
      begin
        b.setpoint = buck_write_in[i].setpoint;
      end
      if (buck_write_in[i].stby_we)
      begin
        b.stby_setpoint = buck_write_in[i].stby_setpoint;
      end

      // sequencer slot reloads the profile; only meaningful during start-up
      if (pwr_state_in != buck_mode_pkg::PWR_STARTUP)
      begin
        b.slot_seen = 1'b0;
      end
      else if (startup_slot_in[i])
      begin
        b.mode      = startup_profile_select_in[i].mode;
        b.setpoint  = startup_profile_select_in[i].setpoint;
        b.slot_seen = 1'b1;
        if (b.phase != buck_mode_pkg::PH_OFF)
        begin
          b.phase = buck_mode_pkg::PH_PFM;
        end
      end

      // wanted mode and set point for the present system state
      hold      = 1'b0;
      lp_bit    = 1'b0;
      want_mode = buck_mode_pkg::MODE_OFF;
      want_sp   = b.setpoint;
      if (pwr_state_in == buck_mode_pkg::PWR_OFF)
      begin
        want_mode = buck_mode_pkg::MODE_OFF;
      end
      else if ((pwr_state_in == buck_mode_pkg::PWR_STARTUP) && !b.slot_seen)
      begin
        hold = 1'b1;
      end
      else if (lp_active)
      begin
        lp_bit    = (pwr_state_in == buck_mode_pkg::PWR_MEMHOLD) ?
                    buck_memhold_mode_in[i] : buck_useroff_mode_in[i];
        want_mode = lp_bit ? buck_mode_pkg::MODE_PFM : buck_mode_pkg::MODE_OFF;
        want_sp   = {1'b0, b.stby_setpoint};
      end
      else if (state_reg.stby)
      begin
        want_mode = buck_mode_pkg::decode_mode(b.mode, 1'b1);
        want_sp   = {1'b0, b.stby_setpoint};
      end
      else
      begin
        want_mode = buck_mode_pkg::decode_mode(b.mode, 1'b0);
      end

      // soft-start sequence and effective mode
      if (!hold)
      begin
        if (want_mode == buck_mode_pkg::MODE_OFF)
        begin
          b.phase      = buck_mode_pkg::PH_OFF;
          b.settle_cnt = '0;
        end
        else
        begin
          b.target = want_sp;
          unique case (b.phase)
            buck_mode_pkg::PH_OFF:
            begin
              b.phase = buck_mode_pkg::PH_PFM;
            end
            buck_mode_pkg::PH_PFM:
            begin
              if (state_reg.tick)
              begin
                b.phase = buck_mode_pkg::PH_APS;
              end
            end
            buck_mode_pkg::PH_APS:
            begin
              if (at_target[i])
              begin
                b.phase      = buck_mode_pkg::PH_PWM;
                b.settle_cnt = SETTLE_LOAD;
              end
            end
            buck_mode_pkg::PH_PWM:
            begin
              if (b.settle_cnt == '0)
              begin
                b.phase = buck_mode_pkg::PH_RUN;
              end
              else
              begin
                b.settle_cnt = b.settle_cnt - buck_mode_pkg::SETTLE_W'(1);
              end
            end
            buck_mode_pkg::PH_RUN:
            begin
              b.phase = buck_mode_pkg::PH_RUN;
            end
            default:
            begin
              b.phase = buck_mode_pkg::PH_OFF;
            end
          endcase
        end
        unique case (b.phase)
          buck_mode_pkg::PH_PFM:  b.eff_mode = buck_mode_pkg::MODE_PFM;
          buck_mode_pkg::PH_APS:  b.eff_mode = buck_mode_pkg::MODE_APS;
          buck_mode_pkg::PH_PWM:  b.eff_mode = buck_mode_pkg::MODE_PWM;
          buck_mode_pkg::PH_RUN:  b.eff_mode = want_mode;
          default:                b.eff_mode = buck_mode_pkg::MODE_OFF;
        endcase
      end

      state_next.bucks[i] = b;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // one slope generator per regulator
  for (genvar g = 0; g < NUM_BUCKS; g++)
  begin : g_slew
    assign ramp_enable[g] = (state_reg.bucks[g].phase != buck_mode_pkg::PH_OFF);

    buck_slew #(
      .W (buck_mode_pkg::SP_W)
    ) u_slew (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .tick_in       (state_reg.tick),
      .enable_in     (ramp_enable[g]),
      .target_in     (state_reg.bucks[g].target),
      .code_out      (vout_code[g]),
      .at_target_out (at_target[g])
    );

    // readback shows the stored fields, never the effective mode
    assign buck_mode_out[g]             = state_reg.bucks[g].eff_mode;
    assign buck_mode_select_out[g]      = state_reg.bucks[g].mode;
    assign buck_standby_setpoint_out[g] = state_reg.bucks[g].stby_setpoint;
    assign buck_vout_code_out[g]        = vout_code[g];
    assign buck_power_good_out[g]       = at_target[g];
  end

  assign standby_active_out = state_reg.stby;

endmodule : buck_standby_mode_control

// [buck_mode_pkg.sv]
// shared types, timing constants and mode decode for the buck mode control block
package buck_mode_pkg;

  // system clock and slow timebase
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SLOW_HZ        = 32_768;
  localparam int unsigned TICK_CYCLES    = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
  localparam int unsigned TICK_W         = 12;

  // soft-start settle time after regulation is reached
  localparam int unsigned SETTLE_TIME_US = 3000;
  localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_W       = 20;

  // field widths
  localparam int unsigned MODE_W         = 4;
  localparam int unsigned SP_W           = 6;
  localparam int unsigned STBY_SP_W      = 5;
  localparam int unsigned DLY_W          = 2;

  // delay field code with no entry delay
  localparam logic [DLY_W-1:0] STBY_DLY_NONE = 2'h0;

  // regulator switching modes
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PFM,
    MODE_APS,
    MODE_PWM
  } op_mode_t;

  // phase of the main power state machine seen by this block
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_STARTUP,
    PWR_WATCHDOG,
    PWR_ON,
    PWR_MEMHOLD,
    PWR_USEROFF
  } pwr_state_t;

  // soft-start progress of one regulator
  typedef enum logic [2:0] {
    PH_OFF,
    PH_PFM,
    PH_APS,
    PH_PWM,
    PH_RUN
  } ss_phase_t;

  // start-up profile defaults for one regulator
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [SP_W-1:0]   setpoint;
  } buck_cfg_t;

  // software write port for one regulator
  typedef struct packed {
    logic                 mode_we;
    logic [MODE_W-1:0]    mode;
    logic                 sp_we;
    logic [SP_W-1:0]      setpoint;
    logic                 stby_we;
    logic [STBY_SP_W-1:0] stby_setpoint;
  } buck_write_t;

  // held state of one regulator
  typedef struct packed {
    logic [MODE_W-1:0]    mode;
    logic [SP_W-1:0]      setpoint;
    logic [STBY_SP_W-1:0] stby_setpoint;
    logic                 slot_seen;
    ss_phase_t            phase;
    logic [SETTLE_W-1:0]  settle_cnt;
    op_mode_t             eff_mode;
    logic [SP_W-1:0]      target;
  } buck_state_t;

  // mode field to normal or standby mode; reserved codes give off
  function automatic op_mode_t decode_mode(input logic [MODE_W-1:0] code, input logic standby);
    op_mode_t nrm;
    op_mode_t sby;
    nrm = MODE_OFF;
    sby = MODE_OFF;
    unique case (code)
      4'h1:    nrm = MODE_PWM;
      4'h3:    nrm = MODE_PFM;
      4'h4:    nrm = MODE_APS;
      4'h5:    begin nrm = MODE_PWM; sby = MODE_PWM; end
      4'h6:    begin nrm = MODE_PWM; sby = MODE_APS; end
      4'h8:    begin nrm = MODE_APS; sby = MODE_APS; end
      4'hc:    begin nrm = MODE_APS; sby = MODE_PFM; end
      4'hd:    begin nrm = MODE_PWM; sby = MODE_PFM; end
      4'hf:    begin nrm = MODE_PFM; sby = MODE_PFM; end
      default: begin nrm = MODE_OFF; sby = MODE_OFF; end
    endcase
    return standby ? sby : nrm;
  endfunction : decode_mode

endpackage : buck_mode_pkg

// [buck_slew.sv]
// controlled-slope set point ramp and at-target flag for one regulator
`timescale 1ns/10ps
module buck_slew #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         tick_in,
  input  wire logic         enable_in,
  input  wire logic [W-1:0] target_in,
  output logic      [W-1:0] code_out,
  output logic              at_target_out
);

  typedef struct packed {
    logic [W-1:0] code;
    logic         at;
  } slew_state_t;

  slew_state_t state_reg;
  slew_state_t state_next;

  // one step per slow tick towards the target; off discharges to zero
  always_comb
  begin
    state_next = state_reg;
    if (!enable_in)
    begin
      state_next.code = '0;
    end
    else if (tick_in && (state_reg.code < target_in))
    begin
      state_next.code = state_reg.code + W'(1);
    end
    else if (tick_in && (state_reg.code > target_in))
    begin
      state_next.code = state_reg.code - W'(1);
    end
    // good drops while the target differs from the output
    state_next.at = enable_in && (state_next.code == target_in);
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign code_out      = state_reg.code;
  assign at_target_out = state_reg.at;

endmodule : buck_slew

// [buck_mode_sva.sv]
// port assertions for the buck mode control block
`timescale 1ns/10ps
module buck_mode_sva #(
  parameter int unsigned NUM_BUCKS = 6
) (
  input wire logic                                          clk_in,
  input wire logic                                          rst_in,
  input wire logic                                          standby_pin_in,
  input wire logic                                          standby_polarity_invert_in,
  input wire logic [buck_mode_pkg::DLY_W-1:0]               standby_entry_delay_in,
  input wire buck_mode_pkg::pwr_state_t                     pwr_state_in,
  input wire logic [NUM_BUCKS-1:0]                          startup_slot_in,
  input wire buck_mode_pkg::buck_cfg_t [NUM_BUCKS-1:0]      startup_profile_select_in,
  input wire buck_mode_pkg::buck_write_t [NUM_BUCKS-1:0]    buck_write_in,
  input wire logic [NUM_BUCKS-1:0]                          buck_memhold_mode_in,
  input wire logic [NUM_BUCKS-1:0]                          buck_useroff_mode_in,
  input wire logic                                          standby_active_out,
  input wire buck_mode_pkg::op_mode_t [NUM_BUCKS-1:0]       buck_mode_out,
  input wire logic [NUM_BUCKS-1:0][buck_mode_pkg::SP_W-1:0] buck_vout_code_out,
  input wire logic [NUM_BUCKS-1:0][3:0]                     buck_mode_select_out
);
  localparam int T = buck_mode_pkg::TICK_CYCLES;
  logic                    lvl;
  logic [5:0]              c0;
  buck_mode_pkg::op_mode_t m0;
  logic [15:0]             cnt_reg;
  logic [15:0]             cnt_next;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // qualified request and buck 0 views
  assign lvl = standby_pin_in ^ standby_polarity_invert_in;
  assign c0 = buck_vout_code_out[0];
  assign m0 = buck_mode_out[0];
  assign cnt_next = (lvl && pwr_state_in == buck_mode_pkg::PWR_ON) ? cnt_reg + 16'h1 : 16'h0;

  // cycles the request has been held while on
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      cnt_reg <= 16'h0;
    else
      cnt_reg <= cnt_next;

  AST_NOT_ON: assert property (pwr_state_in != buck_mode_pkg::PWR_ON |=> !standby_active_out)
    else $error("standby outside on");
  AST_EXIT: assert property (!lvl [*3] |=> !standby_active_out)
    else $error("exit delayed");
  AST_NODLY: assert property ((lvl && pwr_state_in == buck_mode_pkg::PWR_ON && standby_entry_delay_in == 2'h0)
    [*3] |=> standby_active_out) else $error("entry late");
  AST_DLY_LATE: assert property (pwr_state_in == buck_mode_pkg::PWR_ON && standby_entry_delay_in != 2'h0
    && cnt_reg == (standby_entry_delay_in + 1) * T + 6 |-> standby_active_out) else $error("delayed entry late");
  AST_READBACK: assert property (buck_write_in[0].mode_we && !startup_slot_in[0]
    |=> buck_mode_select_out[0] == $past(buck_write_in[0].mode)) else $error("readback wrong");
  AST_RELOAD: assert property (pwr_state_in == buck_mode_pkg::PWR_STARTUP && startup_slot_in[0]
    |=> buck_mode_select_out[0] == $past(startup_profile_select_in[0].mode)) else $error("slot reload wrong");
  AST_STEP: assert property ($changed(c0) && c0 != 6'h0
    |-> c0 == $past(c0) + 6'h1 || c0 == $past(c0) - 6'h1) else $error("set point stepped");
  AST_SS_PFM: assert property ($past(m0) == buck_mode_pkg::MODE_OFF && m0 != buck_mode_pkg::MODE_OFF
    |-> m0 == buck_mode_pkg::MODE_PFM) else $error("no pfm start");
  AST_MEMHOLD: assert property ((pwr_state_in == buck_mode_pkg::PWR_MEMHOLD && !buck_memhold_mode_in[1]) [*2]
    |-> buck_mode_out[1] == buck_mode_pkg::MODE_OFF) else $error("memhold not off");
  AST_USEROFF: assert property ((pwr_state_in == buck_mode_pkg::PWR_USEROFF && !buck_useroff_mode_in[1]) [*2]
    |-> buck_mode_out[1] == buck_mode_pkg::MODE_OFF) else $error("useroff not off");
endmodule : buck_mode_sva

bind buck_standby_mode_control buck_mode_sva #(.NUM_BUCKS(NUM_BUCKS)) u_sva (.*);

// [host_standby_model.sv]
// host model driving the standby pin
`timescale 1ns/10ps
module host_standby_model (
  input  wire logic clk_in,
  input  wire logic want_in,
  input  wire logic invert_in,
  output logic      pin_out
);
  initial pin_out = 1'b0;

  // pin follows the wanted state through the chosen polarity
  always @(posedge clk_in)
    pin_out <= want_in ^ invert_in;
endmodule : host_standby_model

// [buck_standby_mode_control_test.sv]
// self-checking bench for the buck mode control block
`timescale 1ns/10ps
module buck_standby_mode_control_test;
  localparam int T = buck_mode_pkg::TICK_CYCLES;
  localparam logic [15:0] OFF_M = 16'(buck_mode_pkg::MODE_OFF);
  localparam logic [15:0] PFM_M = 16'(buck_mode_pkg::MODE_PFM);
  localparam logic [15:0] APS_M = 16'(buck_mode_pkg::MODE_APS);
  localparam logic [15:0] PWM_M = 16'(buck_mode_pkg::MODE_PWM);
  localparam logic [63:0] CODES = 64'h1345_68cd_f027_9abe;
  localparam logic [31:0] NRM = {2'h3, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3, 2'h1, 14'h0};
  localparam logic [31:0] SBY = {6'h0, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 14'h0};
  logic                             clk_in = 1'b0;
  logic                             rst_in = 1'b1;
  logic                             want = 1'b0;
  logic                             pin;
  logic                             pol = 1'b0;
  logic [1:0]                       dly = 2'h0;
  buck_mode_pkg::pwr_state_t        pwr = buck_mode_pkg::PWR_OFF;
  logic                             lpo = 1'b0;
  logic [1:0]                       slot = 2'h0;
  logic [1:0]                       mh = 2'h0;
  logic [1:0]                       uo = 2'h0;
  buck_mode_pkg::buck_cfg_t [1:0]   prof = {10'h0c1, 10'h102};
  buck_mode_pkg::buck_write_t [1:0] wr = '0;
  logic                             sa;
  buck_mode_pkg::op_mode_t [1:0]    mode;
  logic [1:0][5:0]                  code;
  logic [1:0]                       pg;
  logic [1:0][3:0]                  msel;
  logic [1:0][4:0]                  ssp;
  int                               n_mismatch = 0;
  int                               num_checks = 0;
  int                               cycles = 0;

  buck_standby_mode_control #(.NUM_BUCKS(2), .SETTLE_CYCLES(20)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .standby_pin_in(pin), .standby_polarity_invert_in(pol),
    .standby_entry_delay_in(dly), .pwr_state_in(pwr), .low_power_off_request_in(lpo),
    .startup_slot_in(slot), .startup_profile_select_in(prof), .buck_write_in(wr),
    .buck_memhold_mode_in(mh), .buck_useroff_mode_in(uo), .standby_active_out(sa),
    .buck_mode_out(mode), .buck_vout_code_out(code), .buck_power_good_out(pg),
    .buck_mode_select_out(msel), .buck_standby_setpoint_out(ssp));

  host_standby_model u_host (.clk_in(clk_in), .want_in(want), .invert_in(pol), .pin_out(pin));

  // clock and hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic stby(input logic v);
    @(posedge clk_in);
    want <= v;
  endtask : stby

  // one-cycle write: k 0 mode, 1 set point, 2 standby set point
  task automatic put(input int b, input int k, input logic [5:0] v);
    @(posedge clk_in);
    wr[b] <= {k == 0, v[3:0], k == 1, v, k == 2, v[4:0]};
    @(posedge clk_in);
    wr[b] <= '0;
  endtask : put

  task automatic t_reset();
    cyc(2);
    chk("msel0", 16'h4, 16'(msel[0]));
    chk("ssp0", 16'h2, 16'(ssp[0]));
    chk("ssp1", 16'h1, 16'(ssp[1]));
    $display("t_reset done");
  endtask : t_reset

  task automatic t_soft();
    buck_mode_pkg::op_mode_t q[$];
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_ON;
    q.push_back(mode[0]);
    for (int n = 0; n < 6 * T && q.size() < 5; n++)
    begin
      cyc(1);
      if (mode[0] !== q[$])
        q.push_back(mode[0]);
    end
    chk("ss_first", PFM_M, 16'(q[1]));
    chk("ss_aps", APS_M, 16'(q[2]));
    chk("ss_pwm", PWM_M, 16'(q[3]));
    chk("ss_sel", APS_M, 16'(q[4]));
    chk("ss_pg", 16'h1, 16'(pg[0]));
    $display("t_soft done");
  endtask : t_soft

  task automatic t_slope();
    int n;
    put(0, 1, 6'h04);
    cyc(3);
    chk("pg_drop", 16'h0, 16'(pg[0]));
    for (n = 0; n < T + 10 && code[0] === 6'h02; n++) cyc(1);
    chk("step", 16'h3, 16'(code[0]));
    chk("pg_mid", 16'h0, 16'(pg[0]));
    for (n = 0; n < T + 10 && pg[0] !== 1'b1; n++) cyc(1);
    chk("code_end", 16'h4, 16'(code[0]));
    $display("t_slope done");
  endtask : t_slope

  task automatic t_ignore();
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_WATCHDOG;
    stby(1'b1);
    cyc(8);
    chk("ignore", 16'h0, 16'(sa));
    stby(1'b0);
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_ON;
    cyc(4);
    $display("t_ignore done");
  endtask : t_ignore

  task automatic t_pol();
    @(posedge clk_in);
    pol <= 1'b1;
    want <= 1'b1;
    cyc(6);
    chk("pin_low", 16'h0, 16'(pin));
    chk("sby_on", 16'h1, 16'(sa));
    stby(1'b0);
    cyc(6);
    chk("sby_off", 16'h0, 16'(sa));
    $display("t_pol done");
  endtask : t_pol

  task automatic t_dly(input logic [1:0] d, input int pre);
    int n;
    @(posedge clk_in);
    dly <= d;
    if (pre > 0)
    begin
      stby(1'b1);
      cyc(pre);
      stby(1'b0);
      cyc(T);
      chk("cancel", 16'h0, 16'(sa));
    end
    stby(1'b1);
    for (n = 0; n < 5 * T && sa !== 1'b1; n++) cyc(1);
    chk("dly_min", 16'h1, 16'(n >= (d - 1) * T));
    chk("dly_max", 16'h1, 16'(n <= (d + 1) * T + 8));
    stby(1'b0);
    cyc(6);
    chk("dly_exit", 16'h0, 16'(sa));
    $display("t_dly done");
  endtask : t_dly

  task automatic t_modes(input int lo, input int hi);
    logic [3:0] c;
    @(posedge clk_in);
    dly <= 2'h0;
    // standby left buck 0 in soft-start; let it reach the selected mode
    for (int n = 0; lo == 0 && n < 4 * T && 16'(mode[0]) !== PWM_M; n++) cyc(1);
    if (lo == 0) cyc(25);
    for (int i = lo; i <= hi; i++)
    begin
      c = CODES[63 - 4 * i -: 4];
      put(0, 0, {2'h0, c});
      cyc(3);
      chk("msel", 16'(c), 16'(msel[0]));
      chk("mode_nrm", 16'(NRM[31 - 2 * i -: 2]), 16'(mode[0]));
      if (SBY[31 - 2 * i -: 2] != 2'h0)
      begin
        stby(1'b1);
        cyc(6);
        chk("mode_sby", 16'(SBY[31 - 2 * i -: 2]), 16'(mode[0]));
        chk("msel_sby", 16'(c), 16'(msel[0]));
        stby(1'b0);
        cyc(6);
      end
    end
    $display("t_modes done");
  endtask : t_modes

  task automatic t_lpo();
    int n;
    put(0, 0, 6'h05);
    put(0, 2, 6'h06);
    stby(1'b1);
    @(posedge clk_in);
    uo <= 2'h1;
    lpo <= 1'b1;
    cyc(4);
    chk("lpo_b0", PFM_M, 16'(mode[0]));
    chk("lpo_b1", OFF_M, 16'(mode[1]));
    for (n = 0; n < 4 * T && code[0] !== 6'h06; n++) cyc(1);
    chk("lpo_sp", 16'h6, 16'(code[0]));
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_USEROFF;
    cyc(4);
    chk("uo_b0", PFM_M, 16'(mode[0]));
    @(posedge clk_in);
    mh <= 2'h1;
    pwr <= buck_mode_pkg::PWR_MEMHOLD;
    cyc(4);
    chk("mh_b0", PFM_M, 16'(mode[0]));
    chk("mh_b1", OFF_M, 16'(mode[1]));
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_STARTUP;
    cyc(8);
    chk("hold_mode", PFM_M, 16'(mode[0]));
    chk("hold_sp", 16'h6, 16'(code[0]));
    @(posedge clk_in);
    slot <= 2'h1;
    @(posedge clk_in);
    slot <= 2'h0;
    cyc(2);
    chk("reload", 16'h4, 16'(msel[0]));
    chk("no_off", PFM_M, 16'(mode[0]));
    @(posedge clk_in);
    pwr <= buck_mode_pkg::PWR_ON;
    lpo <= 1'b0;
    stby(1'b0);
    cyc(2);
    $display("t_lpo done");
  endtask : t_lpo

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_soft();
    t_slope();
    t_ignore();
    t_pol();
    t_dly(2'h1, 0);
    t_dly(2'h2, 0);
    t_dly(2'h3, 0);
    t_dly(2'h3, T);
    t_modes(0, 8);
    t_lpo();
    t_modes(9, 15);
    test_done();
  end
endmodule : buck_standby_mode_control_test
